// ### design/tsal_pkg.sv
`default_nettype none
package tsal_pkg;

  // ==========================================================
  // Memory map and reset contents
  localparam int unsigned BLK_N     = 16;
  localparam int unsigned LOCK_LSB  = 16;
  localparam logic [7:0]  SYS_ADDR  = 8'hFF;
  localparam logic [7:0]  OTP_LAST  = 8'h04;
  localparam logic [7:0]  CNT_A     = 8'h05;
  localparam logic [7:0]  CNT_B     = 8'h06;
  localparam logic [31:0] BLK_RST   = 32'hFFFFFFFF;
  localparam logic [31:0] CNT_A_RST = 32'hFFFFFFFE;
  localparam logic [31:0] CNT_B_RST = 32'hFFFFFFFF;
  localparam logic [31:0] SYS_RST   = 32'hFFFFFFFF;

  // ==========================================================
  // Frame check and random source
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'h8408;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam int unsigned RX_MAX    = 8;
  localparam int unsigned TX_MAX    = 10;

  // ==========================================================
  // Command codes and payload lengths
  localparam logic [7:0] CMD_WAKE   = 8'h01;
  localparam logic [7:0] CMD_POLL   = 8'h02;
  localparam logic [7:0] CMD_SLOT   = 8'h03;
  localparam logic [7:0] CMD_CHOOSE = 8'h04;
  localparam logic [7:0] CMD_DONE   = 8'h05;
  localparam logic [7:0] CMD_READ   = 8'h06;
  localparam logic [7:0] CMD_WRITE  = 8'h07;
  localparam logic [7:0] CMD_UID    = 8'h08;
  localparam logic [3:0] LEN_ONE    = 4'h1;
  localparam logic [3:0] LEN_ARG    = 4'h2;
  localparam logic [3:0] LEN_WRITE  = 4'h6;

  typedef enum logic [4:0] {
    TS_READY = 5'h01,
    TS_INV   = 5'h02,
    TS_SEL   = 5'h04,
    TS_DESEL = 5'h08,
    TS_DEACT = 5'h10
  } tsal_state_t;

  // Received character stream, one event per cycle
  typedef struct packed {
    logic       sof;
    logic       eof;
    logic       valid;
    logic [9:0] chr;
  } tsal_rx_t;

  // Answer character with frame markers
  typedef struct packed {
    logic       first;
    logic       last;
    logic [9:0] chr;
  } tsal_txc_t;

  typedef struct packed {
    tsal_state_t                  st;
    logic [7:0]                   id;
    logic [15:0]                  lock;
    logic [15:0]                  lfsr;
    logic                         answered;
    logic                         in_frame;
    logic                         bad;
    logic [3:0]                   nb;
    logic [RX_MAX-1:0][7:0]       rxb;
    logic                         tx_busy;
    logic [3:0]                   tx_len;
    logic [3:0]                   tx_idx;
    logic [TX_MAX-1:0][7:0]       txb;
    logic [BLK_N-1:0][31:0]       mem;
    logic [31:0]                  sys;
  } tsal_core_t;

  function automatic logic [15:0] tsal_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// ### design/tsal_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tsal_fifo import tsal_pkg::*; #(
  parameter int unsigned W     = 12,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } tsal_fifo_st_t;

  tsal_fifo_st_t f_q, f_d;
  logic push, pop;

  assign in_ready  = (f_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (f_q.cnt != '0);
  assign out_data  = f_q.mem[f_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.mem[f_q.wp] = in_data;
      f_d.wp = (f_q.wp == AW'(DEPTH - 1)) ? '0 : f_q.wp + AW'(1);
    end
    if (pop) begin
      f_d.rp = (f_q.rp == AW'(DEPTH - 1)) ? '0 : f_q.rp + AW'(1);
    end
    f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  property p_fifo_bound;
    @(posedge ref_clk) disable iff (!reset_n)
    (f_q.cnt == (AW+1)'(DEPTH)) && !pop |=> (f_q.cnt == (AW+1)'(DEPTH)) && $stable(f_q.wp);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo overfilled");

endmodule // tsal_fifo
`default_nettype wire

// ### design/tsal_core.sv
// Function
// - System block writes only clear bits; an all-zero block takes no update.
// - System bits 31..16 lock blocks 15..0; a zero bit rejects writes.
// - Lock bits never return to one; locked blocks stay read-only.
// - Lock changes reach write protection only on a matching choose command.
// - Fixed identifier option holds bits 7..0 and disables random identifiers.
// - Incoming characters are 10 bits, start bit 0 first.
// - Bad command or CRC mismatch gives no answer at all.
// - Answers are 10-bit characters framed, closing with two CRC bytes.
// - After power-up: ready state, random identifier, only wake-up accepted.
// - Wake-up moves ready to inventory; inventory answers anticollision commands.
// - Inventory enters selected only on matching identifier, else stays.
// - Selected runs read, write, unique id; ignores anticollision commands.
// - Selected: mismatching choose deselects, completion deactivates.
// - Deselected: only matching choose returns to selected.
// - Deactivated ignores every command until power loss.
// - New random identifier in ready and on wake-up in inventory.
// - Slot index is identifier bits 3..0.
// - Slot-zero poll draws new slot; zero slot answers with identifier.
// - Slot mark answers only when its argument bits 3..0 equal slot index.
// - Poll gives sixteen reader slots; wake-up is answered at once.
// - At most one answer per anticollision sequence.
// - CRC starts at all ones, low byte first, bits LSB first.
`timescale 1ns/1ps
`default_nettype none
module tsal_core import tsal_pkg::*; #(
  parameter bit          FIXED_EN = 1'b0,
  parameter logic [7:0]  FIXED_ID = 8'h5A,
  // Arbitrary unique identifier value
  parameter logic [63:0] UID      = 64'h0123456789ABCDEF,
  parameter int unsigned DEPTH    = 4
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Decoded request stream
  input  wire tsal_rx_t    rx_in,
  // Answer stream
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output tsal_txc_t        tx_data,
  // Status
  output tsal_state_t      tag_state,
  output logic [7:0]       tag_select_id,
  output logic [15:0]      lock_state
);

  // ==========================================================
  // State and decode results
  tsal_core_t       r_q, n;
  logic             fifo_in_ready;
  tsal_txc_t        fifo_in;
  logic [BLK_N-1:0] we_vec;
  logic             eof_evt;
  logic             crc_ok;
  logic             sel_hit;
  logic             id_hit;
  logic [7:0]       cmd_w;
  logic [3:0]       plen;

  assign tag_state     = r_q.st;
  assign tag_select_id = r_q.id;
  assign lock_state    = r_q.lock;

  // ==========================================================
  // Next state
  always_comb begin
    logic [15:0]      c;
    logic [7:0]       arg;
    logic [31:0]      wd;
    logic [31:0]      old;
    logic [31:0]      nv;
    logic [3:0]       pn;
    logic [3:0]       alen;
    logic [7:0][7:0]  abuf;
    logic             ld_lock;
    c       = CRC_INIT;
    arg     = '0;
    wd      = '0;
    old     = '0;
    nv      = '0;
    pn      = '0;
    alen    = '0;
    abuf    = '0;
    ld_lock = 1'b0;
    n       = r_q;
    we_vec  = '0;
    eof_evt = 1'b0;
    crc_ok  = 1'b0;
    cmd_w   = r_q.rxb[0];
    arg     = r_q.rxb[1];
    id_hit  = (r_q.rxb[1] == r_q.id);
    plen    = r_q.nb - 4'h2;
    wd      = {r_q.rxb[5], r_q.rxb[4], r_q.rxb[3], r_q.rxb[2]};

    n.lfsr = {1'b0, r_q.lfsr[15:1]} ^ (r_q.lfsr[0] ? LFSR_TAPS : 16'h0000);
    if (r_q.st == TS_READY && !FIXED_EN) begin
      n.id = r_q.lfsr[7:0];
    end

    // Answer drain; requests that arrive meanwhile are dropped
    if (r_q.tx_busy) begin
      if (fifo_in_ready) begin
        n.tx_idx = r_q.tx_idx + 4'h1;
        if (r_q.tx_idx == r_q.tx_len - 4'h1) begin
          n.tx_busy = 1'b0;
        end
      end
    end else if (rx_in.sof) begin
      n.in_frame = 1'b1;
      n.nb       = '0;
      n.bad      = 1'b0;
    end else if (r_q.in_frame && rx_in.valid) begin
      if (rx_in.chr[0] || !rx_in.chr[9] || r_q.nb == 4'(RX_MAX)) begin
        n.bad = 1'b1;
      end else begin
        n.rxb[r_q.nb[2:0]] = rx_in.chr[8:1];
        n.nb = r_q.nb + 4'h1;
      end
    end else if (r_q.in_frame && rx_in.eof) begin
      n.in_frame = 1'b0;
      eof_evt    = 1'b1;
      for (int i = 0; i < RX_MAX; i++) begin
        if (i + 2 < int'(r_q.nb)) begin
          c = tsal_crc_byte(c, r_q.rxb[i]);
        end
      end
      c      = ~c;
      crc_ok = !r_q.bad && (r_q.nb >= 4'h3)
               && (r_q.rxb[3'(r_q.nb - 4'h2)] == c[7:0])
               && (r_q.rxb[3'(r_q.nb - 4'h1)] == c[15:8]);
    end

    // Command execution; anything unrecognised stays silent
    if (crc_ok) begin
      unique case (r_q.st)
        TS_READY: begin
          if (cmd_w == CMD_WAKE && plen == LEN_ONE) begin
            n.st       = TS_INV;
            n.answered = 1'b0;
            alen       = 4'h1;
            abuf[0]    = n.id;
          end
        end
        TS_INV: begin
          if (cmd_w == CMD_WAKE && plen == LEN_ONE) begin
            if (!FIXED_EN) begin
              n.id = r_q.lfsr[7:0];
            end
            n.answered = 1'b0;
            alen       = 4'h1;
            abuf[0]    = n.id;
          end else if (cmd_w == CMD_POLL && plen == LEN_ONE) begin
            pn = FIXED_EN ? r_q.id[3:0] : r_q.lfsr[11:8];
            n.id[3:0] = pn;
            if (pn == 4'h0 && !r_q.answered) begin
              n.answered = 1'b1;
              alen       = 4'h1;
              abuf[0]    = n.id;
            end
          end else if (cmd_w == CMD_SLOT && plen == LEN_ARG) begin
            if (arg[3:0] == r_q.id[3:0] && arg[3:0] != 4'h0
                && !r_q.answered) begin
              n.answered = 1'b1;
              alen       = 4'h1;
              abuf[0]    = r_q.id;
            end
          end else if (cmd_w == CMD_CHOOSE && plen == LEN_ARG && id_hit) begin
            n.st    = TS_SEL;
            ld_lock = 1'b1;
            alen    = 4'h1;
            abuf[0] = r_q.id;
          end
        end
        TS_SEL: begin
          if (cmd_w == CMD_CHOOSE && plen == LEN_ARG) begin
            if (id_hit) begin
              ld_lock = 1'b1;
              alen    = 4'h1;
              abuf[0] = r_q.id;
            end else begin
              n.st = TS_DESEL;
            end
          end else if (cmd_w == CMD_DONE && plen == LEN_ONE) begin
            n.st = TS_DEACT;
          end else if (cmd_w == CMD_READ && plen == LEN_ARG) begin
            if (arg == SYS_ADDR) begin
              {abuf[3], abuf[2], abuf[1], abuf[0]} = r_q.sys;
              alen = 4'h4;
            end else if (arg < 8'(BLK_N)) begin
              {abuf[3], abuf[2], abuf[1], abuf[0]} = r_q.mem[arg[3:0]];
              alen = 4'h4;
            end
          end else if (cmd_w == CMD_WRITE && plen == LEN_WRITE) begin
            if (arg == SYS_ADDR) begin
              if (r_q.sys != 32'h0) begin
                n.sys = r_q.sys & wd;
              end
              if (FIXED_EN) begin
                n.sys[7:0] = r_q.sys[7:0];
              end
            end else if (arg < 8'(BLK_N) && r_q.lock[arg[3:0]]) begin
              we_vec[arg[3:0]] = 1'b1;
              old = r_q.mem[arg[3:0]];
              nv  = old;
              if (arg <= OTP_LAST) begin
                nv = (old != 32'h0) ? (old & wd) : old;
              end else if (arg == CNT_A || arg == CNT_B) begin
                nv = (wd < old) ? wd : old;
              end else begin
                nv = wd;
              end
              n.mem[arg[3:0]] = nv;
            end
          end else if (cmd_w == CMD_UID && plen == LEN_ONE) begin
            abuf = UID;
            alen = 4'h8;
          end
        end
        TS_DESEL: begin
          if (cmd_w == CMD_CHOOSE && plen == LEN_ARG && id_hit) begin
            n.st    = TS_SEL;
            ld_lock = 1'b1;
            alen    = 4'h1;
            abuf[0] = r_q.id;
          end
        end
        TS_DEACT: begin
          n.st = TS_DEACT;
        end
      endcase
    end

    sel_hit = ld_lock;
    if (ld_lock) begin
      n.lock = r_q.sys[31:LOCK_LSB];
    end

    // Answer loading with trailing CRC
    if (alen != 4'h0) begin
      c = CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(alen)) begin
          c = tsal_crc_byte(c, abuf[i]);
        end
      end
      c = ~c;
      for (int i = 0; i < TX_MAX; i++) begin
        if (i < int'(alen)) begin
          n.txb[i] = abuf[i % 8];
        end else if (i == int'(alen)) begin
          n.txb[i] = c[7:0];
        end else begin
          n.txb[i] = c[15:8];
        end
      end
      n.tx_len  = alen + 4'h2;
      n.tx_idx  = '0;
      n.tx_busy = 1'b1;
    end
  end

  // Start bit low, stop bit high around the byte
  assign fifo_in.first = (r_q.tx_idx == 4'h0);
  assign fifo_in.last  = (r_q.tx_idx == r_q.tx_len - 4'h1);
  assign fifo_in.chr   = {1'b1, r_q.txb[r_q.tx_idx], 1'b0};

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q          <= '0;
      r_q.st       <= TS_READY;
      r_q.id       <= FIXED_EN ? FIXED_ID : 8'h00;
      r_q.lfsr     <= LFSR_SEED;
      r_q.lock     <= SYS_RST[31:LOCK_LSB];
      r_q.mem      <= {BLK_N{BLK_RST}};
      r_q.mem[5]   <= CNT_A_RST;
      r_q.mem[6]   <= CNT_B_RST;
      r_q.sys      <= FIXED_EN ? {SYS_RST[31:8], FIXED_ID} : SYS_RST;
    end else begin
      r_q <= n;
    end
  end

  // Answer buffer; a stalled drain holds the core in answer mode
  tsal_fifo #(
    .W     ($bits(tsal_txc_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (r_q.tx_busy),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // ==========================================================
  // Checks
  property p_deact_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    r_q.st == TS_DEACT |=> r_q.st == TS_DEACT && !r_q.tx_busy;
  endproperty
  a_deact_hold: assert property (p_deact_hold) else $error("left deactivated");

  property p_sys_clear_only;
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 ((~$past(r_q.sys)) & r_q.sys) == 32'h0;
  endproperty
  a_sys_clear_only: assert property (p_sys_clear_only) else $error("system bit set");

  property p_sys_empty;
    @(posedge ref_clk) disable iff (!reset_n)
    r_q.sys == 32'h0 |=> r_q.sys == 32'h0;
  endproperty
  a_sys_empty: assert property (p_sys_empty) else $error("empty block updated");

  property p_lock_gate;
    @(posedge ref_clk) disable iff (!reset_n)
    (we_vec & ~r_q.lock) == 16'h0000;
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("locked block written");

  property p_lock_mono;
    @(posedge ref_clk) disable iff (!reset_n)
    ##1 ((~$past(r_q.lock)) & r_q.lock) == 16'h0000;
  endproperty
  a_lock_mono: assert property (p_lock_mono) else $error("lock bit released");

  property p_lock_load;
    @(posedge ref_clk) disable iff (!reset_n)
    !sel_hit |=> $stable(r_q.lock);
  endproperty
  a_lock_load: assert property (p_lock_load) else $error("lock moved without choose");

  property p_fixed_id;
    @(posedge ref_clk) disable iff (!reset_n)
    FIXED_EN |-> r_q.id == FIXED_ID && r_q.sys[7:0] == FIXED_ID;
  endproperty
  a_fixed_id: assert property (p_fixed_id) else $error("fixed identifier lost");

  property p_silent_bad;
    @(posedge ref_clk) disable iff (!reset_n)
    eof_evt && !crc_ok |=> !r_q.tx_busy [*2];
  endproperty
  a_silent_bad: assert property (p_silent_bad) else $error("answer to bad frame");

  property p_ready_ignore;
    @(posedge ref_clk) disable iff (!reset_n)
    crc_ok && r_q.st == TS_READY && cmd_w != CMD_WAKE |=> r_q.st == TS_READY && !r_q.tx_busy;
  endproperty
  a_ready_ignore: assert property (p_ready_ignore) else $error("ready took command");

  property p_sel_miss;
    @(posedge ref_clk) disable iff (!reset_n)
    crc_ok && r_q.st == TS_INV && cmd_w == CMD_CHOOSE && !id_hit |=> r_q.st == TS_INV;
  endproperty
  a_sel_miss: assert property (p_sel_miss) else $error("left inventory on mismatch");

  property p_answer_once;
    @(posedge ref_clk) disable iff (!reset_n)
    crc_ok && r_q.st == TS_INV && r_q.answered && cmd_w == CMD_POLL |=> !r_q.tx_busy;
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("second answer");

endmodule // tsal_core
`default_nettype wire

// ### bench/tsal_reader.sv
`timescale 1ns/1ps
`default_nettype none
module tsal_reader import tsal_pkg::*; (
  // Clock
  input  wire logic      ref_clk,
  // Request side
  output tsal_rx_t       rx_out,
  // Answer side
  input  wire logic      tx_valid,
  output logic           tx_ready,
  input  wire tsal_txc_t tx_data,
  input  wire logic      stall_en
);
  logic [7:0] ans_q[$];
  int         frame_err = 0;
  logic       in_ans = 1'b0;

  initial begin
    rx_out = '0;
  end

  // ==========================================================
  // Frame check sequence
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return ~c;
  endfunction

  // ==========================================================
  // Request frames
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    logic [7:0]  f[$];
    f = q;
    // Corrupting one CRC bit lets a scenario provoke a rejected frame
    c = crc16(q) ^ (bad ? 16'h0001 : 16'h0000);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    @(negedge ref_clk);
    rx_out.sof = 1'b1;
    foreach (f[i]) begin
      @(negedge ref_clk);
      rx_out.sof = 1'b0;
      rx_out.valid = 1'b1;
      rx_out.chr = {1'b1, f[i], 1'b0};
    end
    @(negedge ref_clk);
    rx_out.valid = 1'b0;
    rx_out.chr = ~rx_out.chr;
    rx_out.eof = 1'b1;
    @(negedge ref_clk);
    rx_out.eof = 1'b0;
  endtask

  // ==========================================================
  // Answer drain with optional stalls
  always @(negedge ref_clk) begin
    tx_ready <= stall_en ? 1'($urandom % 2) : 1'b1;
  end

  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      if (tx_data.first !== !in_ans) frame_err++;
      if (tx_data.chr[0] !== 1'b0 || tx_data.chr[9] !== 1'b1) frame_err++;
      ans_q.push_back(tx_data.chr[8:1]);
      in_ans = !tx_data.last;
    end
  end
endmodule // tsal_reader
`default_nettype wire

// ### bench/tag_state_anticollision_lock_test.sv
`timescale 1ns/1ps
`default_nettype none
module tag_state_anticollision_lock_test;
  import tsal_pkg::*;
  localparam logic [7:0]  FID  = 8'h5A;
  // Arbitrary value
  localparam logic [63:0] UIDV = 64'h0123456789ABCDEF;

  logic        ref_clk  = 1'b0;
  logic        reset_n  = 1'b0;
  logic        stall_en = 1'b0;
  tsal_rx_t    rx;
  logic        tx_valid;
  logic        tx_ready;
  tsal_txc_t   tx_data;
  tsal_state_t tag_state;
  logic [7:0]  sel_id;
  logic [15:0] lock_state;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  tsal_state_t m_st;
  logic [31:0] m_mem[16];
  logic [31:0] m_sys;
  logic [15:0] m_lock;
  bit          m_ans;
  logic [7:0]  exp_q[$];
  logic [31:0] d;

  always #4 ref_clk = ~ref_clk;

  tsal_core #(.FIXED_EN(1'b1), .FIXED_ID(FID), .UID(UIDV), .DEPTH(4)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .rx_in(rx), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tag_state(tag_state),
    .tag_select_id(sel_id), .lock_state(lock_state));

  tsal_reader rdr (
    .ref_clk(ref_clk), .rx_out(rx), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .stall_en(stall_en));

  // ==========================================================
  // Reporting
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================================
  // Behavioural tag model
  task automatic model(input logic [7:0] q[$]);
    logic [7:0]  a;
    logic [31:0] w;
    a = (q.size() > 1) ? q[1] : 8'h00;
    w = (q.size() > 5) ? {q[5], q[4], q[3], q[2]} : 32'h0;
    exp_q.delete();
    if (q[0] == CMD_CHOOSE && m_st != TS_READY && m_st != TS_DEACT) begin
      if (a == FID) begin
        m_st = TS_SEL;
        m_lock = m_sys[31:16];
        exp_q = '{FID};
      end else if (m_st == TS_SEL) m_st = TS_DESEL;
    end else if (m_st == TS_READY || m_st == TS_INV) begin
      if (q[0] == CMD_WAKE) begin
        m_st = TS_INV;
        m_ans = 1'b0;
        exp_q = '{FID};
      end else if (m_st == TS_INV && !m_ans && ((q[0] == CMD_SLOT && a[3:0] == FID[3:0]
                   && a[3:0] != 4'h0) || (q[0] == CMD_POLL && FID[3:0] == 4'h0))) begin
        m_ans = 1'b1;
        exp_q = '{FID};
      end
    end else if (m_st == TS_SEL) begin
      if (q[0] == CMD_DONE) m_st = TS_DEACT;
      if (q[0] == CMD_UID) for (int i = 0; i < 8; i++) exp_q.push_back(UIDV[8*i +: 8]);
      if (q[0] == CMD_READ && (a < 16 || a == 8'hFF))
        for (int i = 0; i < 4; i++) exp_q.push_back(a == 8'hFF ? m_sys[8*i +: 8] : m_mem[a[3:0]][8*i +: 8]);
      if (q[0] == CMD_WRITE) begin
        if (a == 8'hFF) begin
          if (m_sys != 32'h0) m_sys = m_sys & {w[31:8], 8'hFF};
        end else if (a < 16 && m_lock[a[3:0]]) begin
          if (a < 5) begin
            if (m_mem[a[3:0]] != 32'h0) m_mem[a[3:0]] = m_mem[a[3:0]] & w;
          end else if (a < 7) begin
            if (w < m_mem[a[3:0]]) m_mem[a[3:0]] = w;
          end else m_mem[a[3:0]] = w;
        end
      end
    end
  endtask

  // One request frame, then compare answer, state and lock view
  task automatic xfer(input logic [7:0] q[$], input bit bad = 1'b0);
    logic [15:0] c;
    int          k;
    if (!bad) model(q);
    else exp_q.delete();
    if (exp_q.size() > 0) begin
      c = rdr.crc16(exp_q);
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
    end
    rdr.ans_q.delete();
    rdr.send(q, bad);
    k = 0;
    while (k < 200 && rdr.ans_q.size() < exp_q.size()) begin
      @(negedge ref_clk);
      k++;
    end
    // Quiet period so an unwanted extra answer is caught
    repeat (20) @(negedge ref_clk);
    check("answer length", exp_q.size(), rdr.ans_q.size());
    foreach (exp_q[i]) if (i < rdr.ans_q.size()) check("answer byte", exp_q[i], rdr.ans_q[i]);
    check("state", m_st, tag_state);
    check("lock", m_lock, lock_state);
    check("identifier", FID, sel_id);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer('{CMD_WRITE, a, v[7:0], v[15:8], v[23:16], v[31:24]});
    xfer('{CMD_READ, a});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hEEAE7D84));
    m_st = TS_READY;
    m_ans = 1'b0;
    m_lock = 16'hFFFF;
    m_sys = {24'hFFFFFF, FID};
    foreach (m_mem[i]) m_mem[i] = 32'hFFFFFFFF;
    m_mem[5] = 32'hFFFFFFFE;
    repeat (12) @(negedge ref_clk);
    reset_n = 1'b1;
    check("reset state", TS_READY, tag_state);
    check("reset lock", 16'hFFFF, lock_state);
    stall_en = 1'b1;
    xfer('{CMD_POLL});
    xfer('{CMD_CHOOSE, FID});
    xfer('{CMD_WAKE}, 1'b1);
    xfer('{CMD_WAKE});
    xfer('{CMD_WAKE});
    xfer('{CMD_POLL});
    for (int s = 0; s < 16; s++) xfer('{CMD_SLOT, 8'(s)});
    xfer('{CMD_POLL});
    xfer('{CMD_CHOOSE, FID ^ 8'h01});
    xfer('{CMD_CHOOSE, FID});
    xfer('{CMD_WAKE});
    xfer('{CMD_POLL});
    xfer('{8'h09});
    xfer('{CMD_UID});
    foreach (m_mem[i]) begin
      d = $urandom;
      wr(8'(i), d);
    end
    wr(8'h00, $urandom);
    wr(8'hFF, 32'hFF7FFFFF);
    wr(8'h07, $urandom);
    xfer('{CMD_CHOOSE, FID});
    wr(8'h07, $urandom);
    wr(8'hFF, 32'hFFFFFFFF);
    xfer('{CMD_CHOOSE, FID});
    wr(8'h07, $urandom);
    xfer('{CMD_READ, 8'h10});
    xfer('{CMD_CHOOSE, 8'h00});
    xfer('{CMD_READ, 8'h07});
    xfer('{CMD_CHOOSE, FID});
    xfer('{CMD_DONE});
    xfer('{CMD_WAKE});
    xfer('{CMD_CHOOSE, FID});
    check("answer framing", 0, rdr.frame_err);
    finish_test();
  end
endmodule // tag_state_anticollision_lock_test
`default_nettype wire
